// ---- logic/level_mask_pkg.sv ----
// constants for the level-threshold interrupt enable masks
package level_mask_pkg;
    localparam int slot_count = 12;
    localparam int addr_width = 16;
    localparam int data_width = 16;
    localparam logic [15:0] mask_x0_offset = 16'h0016;
    localparam logic [15:0] mask_x1_offset = 16'h0017;
    localparam logic [15:0] mask_y0_offset = 16'h001A;
    localparam logic [15:0] mask_y1_offset = 16'h001B;
    localparam int slot_a_bit = 0;
    localparam int slot_e_bit = 4;
    localparam int slot_l_bit = 11;
    localparam logic [11:0] mask_reset = 12'h000;
    localparam int read_latency = 1;
endpackage

// ---- logic/mask_gate.sv ----
// one output's gating of two levels of slot flags by their enables
`timescale 1ns/1ns
module mask_gate #(
    parameter int slots = 12
) (
    // flags
    input wire logic [slots-1:0] level_zero_flags,
    input wire logic [slots-1:0] level_one_flags,
    // enables
    input wire logic [slots-1:0] level_zero_enables,
    input wire logic [slots-1:0] level_one_enables,
    // result
    output logic line
);
    logic [slots-1:0] hit;

    // each slot bit acts on its own
    for (genvar i = 0; i < slots; i++) begin : g_slot
        assign hit[i] = (level_zero_flags[i] & level_zero_enables[i]) | (level_one_flags[i] & level_one_enables[i]);
    end

    // or of all enabled statuses
    assign line = |hit;
endmodule

// ---- logic/level_interrupt_enable_masks.sv ----
// enable masks routing per-slot level statuses onto interrupt outputs x and y
// Contract
// - mask at 0x0017, bits 11:0, routes level-one slot flags to output x.
// - mask at 0x001A, bits 11:0, routes level-zero slot flags to output y.
// - mask at 0x001B, bits 11:0, routes level-one slot flags to output y.
// - level-zero x mask bits 4:0 enable slots E down to A.
// - bit 0 is slot A, bit 11 is slot L; bits act independently.
// - mask at 0x0016, bits 11:0, routes level-zero slot flags to output x.
`timescale 1ns/1ns
module level_interrupt_enable_masks #(
    parameter int slots = level_mask_pkg::slot_count
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [level_mask_pkg::addr_width-1:0] reg_addr,
    input wire logic [level_mask_pkg::data_width-1:0] reg_wdata,
    output logic [level_mask_pkg::data_width-1:0] reg_rdata,
    output logic reg_rvalid,
    // threshold status flags, bit 0 is slot a
    input wire logic [slots-1:0] level_zero_flags,
    input wire logic [slots-1:0] level_one_flags,
    // interrupt outputs
    output logic interrupt_x,
    output logic interrupt_y
);
    if (slots != level_mask_pkg::slot_count) begin : g_check
        $error("slots must be twelve");
    end

    typedef struct packed {
        logic [11:0] mask_x0;
        logic [11:0] mask_x1;
        logic [11:0] mask_y0;
        logic [11:0] mask_y1;
        logic [15:0] rdata;
        logic rvalid;
        logic int_x;
        logic int_y;
    } state_s;

    state_s state_r;
    state_s state_nxt;
    logic line_x;
    logic line_y;
    logic [3:0] addr_sel;

    // one-hot select of the mask at an offset, zero when unmapped
    function automatic logic [3:0] select_of(input logic [15:0] a);
        logic [3:0] s;
        s = 4'h0;
        s[0] = (a == level_mask_pkg::mask_x0_offset);
        s[1] = (a == level_mask_pkg::mask_x1_offset);
        s[2] = (a == level_mask_pkg::mask_y0_offset);
        s[3] = (a == level_mask_pkg::mask_y1_offset);
        return s;
    endfunction

    // selects the mask for an offset, zero when unmapped
    function automatic logic [11:0] mask_at(input state_s s, input logic [15:0] a);
        logic [11:0] m;
        logic [3:0] sel;
        m = 12'h000;
        sel = select_of(a);
        if (sel[0]) begin
            m = s.mask_x0;
        end else if (sel[1]) begin
            m = s.mask_x1;
        end else if (sel[2]) begin
            m = s.mask_y0;
        end else if (sel[3]) begin
            m = s.mask_y1;
        end
        return m;
    endfunction

    assign addr_sel = select_of(reg_addr);

    mask_gate #(.slots(slots)) u_gate_x (
        .level_zero_flags(level_zero_flags),
        .level_one_flags(level_one_flags),
        .level_zero_enables(state_r.mask_x0),
        .level_one_enables(state_r.mask_x1),
        .line(line_x)
    );

    mask_gate #(.slots(slots)) u_gate_y (
        .level_zero_flags(level_zero_flags),
        .level_one_flags(level_one_flags),
        .level_zero_enables(state_r.mask_y0),
        .level_one_enables(state_r.mask_y1),
        .line(line_y)
    );

    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = reg_read;
        if (reg_read) begin
            // reserved bits 15:12 read zero
            state_nxt.rdata = {4'h0, mask_at(state_r, reg_addr)};
        end
        if (reg_write) begin
            // bit 0 slot a .. bit 11 slot l
            if (addr_sel[0]) begin
                state_nxt.mask_x0 = reg_wdata[11:0];
            end
            if (addr_sel[1]) begin
                state_nxt.mask_x1 = reg_wdata[11:0];
            end
            if (addr_sel[2]) begin
                state_nxt.mask_y0 = reg_wdata[11:0];
            end
            if (addr_sel[3]) begin
                state_nxt.mask_y1 = reg_wdata[11:0];
            end
        end
        state_nxt.int_x = line_x;
        state_nxt.int_y = line_y;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
            state_r.mask_x0 <= level_mask_pkg::mask_reset;
            state_r.mask_x1 <= level_mask_pkg::mask_reset;
            state_r.mask_y0 <= level_mask_pkg::mask_reset;
            state_r.mask_y1 <= level_mask_pkg::mask_reset;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign reg_rdata = state_r.rdata;
    assign reg_rvalid = state_r.rvalid;
    assign interrupt_x = state_r.int_x;
    assign interrupt_y = state_r.int_y;
endmodule

// ---- test/host_model.sv ----
// host model driving the mask register port
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    output logic reg_write,
    output logic reg_read,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata
);
    initial {reg_write, reg_read, reg_addr, reg_wdata} = '0;
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk) {reg_write, reg_read, reg_addr, reg_wdata} = {w, !w, a, d};
        @(negedge clk) {reg_write, reg_read, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    endtask
endmodule

// ---- test/mask_props.sv ----
// routing and read-back checks
`timescale 1ns/1ns
module mask_props (
    input wire logic clk, reset_n, reg_write, reg_read, reg_rvalid, interrupt_x, interrupt_y,
    input wire logic [15:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic [11:0] level_zero_flags, level_one_flags
);
    logic [11:0] m [4];
    wire hit = reg_addr inside {16'h0016, 16'h0017, 16'h001A, 16'h001B};
    wire [1:0] ix = {reg_addr[3], reg_addr[0]};
    wire [15:0] rv = hit ? {4'h0, m[ix]} : 16'h0000;
    wire ex = |(level_zero_flags & m[0]) || |(level_one_flags & m[1]);
    wire ey = |(level_zero_flags & m[2]) || |(level_one_flags & m[3]);
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n) m <= '{default: 12'h000};
        else if (reg_write && hit) m[ix] <= reg_wdata[11:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_x_zero_route: assert property (|(level_zero_flags & m[0]) |=> interrupt_x) else $error("x lost level0");
    a_x_one_route: assert property (|(level_one_flags & m[1]) |=> interrupt_x) else $error("x lost level1");
    a_y_zero_route: assert property (|(level_zero_flags & m[2]) |=> interrupt_y) else $error("y lost level0");
    a_y_one_route: assert property (|(level_one_flags & m[3]) |=> interrupt_y) else $error("y lost level1");
    a_x_exact_or: assert property (interrupt_x == $past(ex)) else $error("x not the or");
    a_y_exact_or: assert property (interrupt_y == $past(ey)) else $error("y not the or");
    a_read_back: assert property (reg_read |=> reg_rvalid && reg_rdata == $past(rv)) else $error("bad read");
    cover property (reg_read ##1 reg_rdata != 16'h0000);
    cover property (interrupt_x);
    cover property (interrupt_y);
endmodule

// ---- test/testbench.sv ----
// testbench for the interrupt enable masks
`timescale 1ns/1ns
module testbench;
    logic clk = 0, reset_n = 0, reg_write, reg_read, reg_rvalid, interrupt_x, interrupt_y;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [11:0] level_zero_flags = 0, level_one_flags = 0, m [4] = '{default: 12'h000};
    logic [15:0] offs [4] = '{16'h0016, 16'h0017, 16'h001A, 16'h001B};
    logic [15:0] q [$];
    logic [31:0] seed = 32'hD2DB541B, v;
    int failures = 0, checks_done = 0;
    always #5 clk = ~clk;
    host_model host_model_i (.*);
    level_interrupt_enable_masks level_interrupt_enable_masks_i (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge clk) if (reg_rvalid === 1'b1) check("rdata", reg_rdata, q.pop_front());
    initial begin
        #10000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) reset_n = 1;
        for (int i = 0; i < 4; i++) begin
            q.push_back(16'h0000);
            host_model_i.access(0, offs[i], 0);
        end
        for (int n = 0; n < 40; n++) begin
            v = rnd();
            m[n % 4] = v[11:0];
            host_model_i.access(1, offs[n % 4], v[15:0]);
            host_model_i.access(1, 16'h0019, 16'hFFFF);
            q.push_back({4'h0, m[n % 4]});
            host_model_i.access(0, offs[n % 4], 0);
            q.push_back(16'h0000);
            host_model_i.access(0, 16'h0019, 0);
            @(negedge clk) {level_zero_flags, level_one_flags} = rnd();
            repeat (2) @(negedge clk);
            check("x", interrupt_x, |(level_zero_flags & m[0]) || |(level_one_flags & m[1]));
            check("y", interrupt_y, |(level_zero_flags & m[2]) || |(level_one_flags & m[3]));
        end
        $display("routing test done");
        complete_run();
    end
endmodule
bind level_interrupt_enable_masks mask_props mask_props_i (.*);
